// ### rtl/fabric_consts.vh
// offsets, field positions, reset values and encodings of the macrocell fabric
`ifndef FABRIC_CONSTS_VH
`define FABRIC_CONSTS_VH

// ==========================================================
// register byte offsets
`define OFS_OE_SOURCE       8'h00
`define OFS_FEEDBACK        8'h04
`define OFS_IO_CLK_SEL      8'h08
`define OFS_IO_BYPASS       8'h0C
`define OFS_OUT_BYPASS      8'h10
`define OFS_STATE_CLK_SEL   8'h14
`define OFS_DED_CLK_SEL     8'h18
`define OFS_DED_BYPASS      8'h1C
`define OFS_GLOBAL          8'h20
`define OFS_PAIR_SEL        8'h24
`define OFS_STORAGE_TYPE    8'h28
`define OFS_SPLIT_LOW       8'h2C
`define OFS_SPLIT_HIGH      8'h30
`define OFS_STATE_STATUS    8'h34
`define OFS_FEED_STATUS     8'h38

// ==========================================================
// global register bits
`define GBIT_INPUT_CLOCK_TWO_PIN      0
`define GBIT_INPUT_CLOCK_ONE_PIN      1
`define GBIT_STATE_CLOCK_TWO_PIN      2
`define GBIT_RUN            3

// ==========================================================
// sizes and reset values
`define IO_CELLS            12
`define STATE_REGS          16
`define DED_INPUTS          12
`define PAIRS               6
`define TERMS_PER_PAIR      32
`define SPLIT_WIDTH         6
`define SPLIT_RESET         6'h10
`define CFG_RESET           32'h00000000

// ==========================================================
// storage element types
`define STORE_D             2'h0
`define STORE_T             2'h1
`define STORE_JK            2'h2
`define STORE_RS            2'h3

// ==========================================================
// bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ### rtl/pin_sync.v
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter WIDTH = 28
) (
	input  wire             clock,
	input  wire             rst_b,
	input  wire [WIDTH-1:0] pins,
	output reg  [WIDTH-1:0] synced
);
	reg [WIDTH-1:0] first_reg;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			first_reg <= {WIDTH{1'b0}};
			synced    <= {WIDTH{1'b0}};
		end else begin
			first_reg <= pins;
			synced    <= first_reg;
		end
	end
endmodule // pin_sync

// ### rtl/axi_lite_port.v
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/100ps
`include "fabric_consts.vh"
module axi_lite_port (
	input  wire        clock,
	input  wire        rst_b,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         wr_strobe,
	output reg  [7:0]  wr_addr,
	output reg  [31:0] wr_data,
	output reg  [3:0]  wr_strb,
	input  wire        wr_ok,
	output wire [7:0]  rd_addr,
	input  wire [31:0] rd_data,
	input  wire        rd_ok
);
	reg aw_held;
	reg w_held;

	assign rd_addr = s_axi_araddr;

	always @* begin
		s_axi_awready = !aw_held && !s_axi_bvalid;
		s_axi_wready  = !w_held && !s_axi_bvalid;
		s_axi_arready = !s_axi_rvalid;
		wr_strobe     = aw_held && w_held && !s_axi_bvalid;
	end

	// ==========================================================
	// write channel
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			wr_addr      <= 8'h00;
			wr_data      <= 32'h00000000;
			wr_strb      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held  <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (wr_strobe) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// read channel
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_ok ? rd_data : 32'h00000000;
			s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // axi_lite_port

// ### rtl/state_macrocell_fabric.v
// configurable macrocell fabric: io cells, hidden state registers, dedicated inputs
// What this block does
// - per io cell, oe select 0 takes product term oe, 1 takes common oe pin.
// - feedback select 0 feeds state register back; 1 feeds input path to array.
// - io input register clocked by input clock one at 0, two at 1.
// - io bypass 0 feeds feedback mux from input register, 1 from pin.
// - output bypass 0 drives pin from state register, 1 from array sum.
// - all sixteen state registers choose state clock one at 0, two at 1.
// - dedicated input registers clocked by input clock one at 0, two at 1.
// - dedicated bypass 0 gives array registered input, 1 gives the pin directly.
// - global bit picks input clock two from pin two, or pin three when set.
// - global bit picks input clock one from pin two, or pin one when set.
// - state clock two is grounded while its select bit is clear.
// - state clock two comes from pin three when its select bit is set.
// - each io pair has an input mux so a hidden cell pin still serves.
// - pair select 0 takes first cell input path, 1 the second cell.
// - four pinless hidden state registers; all twelve io registers may be hidden.
// - 192 product terms, 32 per pair, split variably between pair cells.
// - global synchronous set and reset terms, sampled on input clock one.
// - io state registers behave as jk, rs, t or d storage.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "fabric_consts.vh"
module state_macrocell_fabric (
	input  wire         clock,
	input  wire         rst_b,
	input  wire [7:0]   s_axi_awaddr,
	input  wire         s_axi_awvalid,
	output wire         s_axi_awready,
	input  wire [31:0]  s_axi_wdata,
	input  wire [3:0]   s_axi_wstrb,
	input  wire         s_axi_wvalid,
	output wire         s_axi_wready,
	output wire [1:0]   s_axi_bresp,
	output wire         s_axi_bvalid,
	input  wire         s_axi_bready,
	input  wire [7:0]   s_axi_araddr,
	input  wire         s_axi_arvalid,
	output wire         s_axi_arready,
	output wire [31:0]  s_axi_rdata,
	output wire [1:0]   s_axi_rresp,
	output wire         s_axi_rvalid,
	input  wire         s_axi_rready,
	input  wire         clk_pin_one,
	input  wire         clk_pin_two,
	input  wire         clk_pin_three,
	input  wire         common_oe_pin,
	input  wire [11:0]  io_pin_in,
	output reg  [11:0]  io_pin_out,
	output reg  [11:0]  io_pin_oe,
	input  wire [11:0]  dedicated_pin,
	input  wire [191:0] product_terms,
	input  wire [11:0]  second_terms,
	input  wire [11:0]  oe_terms,
	input  wire [3:0]   hidden_terms,
	input  wire         set_term,
	input  wire         reset_term,
	output reg  [11:0]  dedicated_feed,
	output reg  [11:0]  macrocell_feed,
	output reg  [5:0]   pair_feed,
	output reg  [3:0]   hidden_feed
);
	// ==========================================================
	// functions
	function [31:0] merge_bytes;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer b;
		begin
			merge_bytes = old_val;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b]) begin
					merge_bytes[b*8 +: 8] = new_val[b*8 +: 8];
				end
			end
		end
	endfunction

	// terms below the split go to the first cell, the rest to the second
	function cell_sum;
		input [31:0] terms;
		input [5:0]  split;
		input        second_cell;
		integer t;
		begin
			cell_sum = 1'b0;
			for (t = 0; t < 32; t = t + 1) begin
				if (((t < split) ^ second_cell) && terms[t]) begin
					cell_sum = 1'b1;
				end
			end
		end
	endfunction

	function next_state;
		input [1:0] kind;
		input       q;
		input       a;
		input       b;
		begin
			case (kind)
				`STORE_D:  next_state = a;
				`STORE_T:  next_state = q ^ a;
				`STORE_JK: next_state = (a & ~q) | (~b & q);
				`STORE_RS: next_state = a | (~b & q);
				default:   next_state = a;
			endcase
		end
	endfunction

	// ==========================================================
	// reset release
	reg rst_meta_reg;
	reg rst_sync_b;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_sync_b   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_b   <= rst_meta_reg;
		end
	end

	// ==========================================================
	// pin synchronisers
	wire [27:0] synced;
	wire        pin_one_s  = synced[0];
	wire        pin_two_s  = synced[1];
	wire        pin_three_s = synced[2];
	wire        oe_pin_s   = synced[3];
	wire [11:0] io_s       = synced[15:4];
	wire [11:0] ded_s      = synced[27:16];

	pin_sync #(
		.WIDTH (28)
	) u_sync (
		.clock  (clock),
		.rst_b  (rst_sync_b),
		.pins   ({dedicated_pin, io_pin_in, common_oe_pin, clk_pin_three, clk_pin_two,
			clk_pin_one}),
		.synced (synced)
	);

	// ==========================================================
	// configuration registers
	reg [11:0] oe_source_select;
	reg [11:0] feedback_select;
	reg [11:0] io_input_clock_select;
	reg [11:0] io_input_bypass;
	reg [11:0] output_register_bypass;
	reg [15:0] state_clock_select;
	reg [11:0] dedicated_input_clock_select;
	reg [11:0] dedicated_input_bypass;
	reg [3:0]  global_reg;
	reg [5:0]  pair_input_select;
	reg [23:0] storage_type;
	reg [35:0] split_reg;

	wire        wr_strobe;
	wire [7:0]  wr_addr;
	wire [31:0] wr_data;
	wire [3:0]  wr_strb;
	wire [7:0]  rd_addr;
	reg  [31:0] rd_data;
	reg         rd_ok;
	reg         wr_ok;
	reg         wr_known;
	reg  [31:0] wr_old;
	reg  [31:0] wr_val;

	wire input_clock_two_pin_select = global_reg[`GBIT_INPUT_CLOCK_TWO_PIN];
	wire input_clock_one_pin_select = global_reg[`GBIT_INPUT_CLOCK_ONE_PIN];
	wire state_clock_two_pin_select = global_reg[`GBIT_STATE_CLOCK_TWO_PIN];
	wire run                        = global_reg[`GBIT_RUN];

	reg [15:0] state_q;

	axi_lite_port u_bus (
		.clock         (clock),
		.rst_b         (rst_sync_b),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_strobe     (wr_strobe),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_ok         (wr_ok),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_ok         (rd_ok)
	);

	// read decode shared by the write path for byte merging
	function [32:0] reg_view;
		input [7:0] addr;
		begin
			case (addr)
				`OFS_OE_SOURCE:     reg_view = {1'b1, 20'h00000, oe_source_select};
				`OFS_FEEDBACK:      reg_view = {1'b1, 20'h00000, feedback_select};
				`OFS_IO_CLK_SEL:    reg_view = {1'b1, 20'h00000, io_input_clock_select};
				`OFS_IO_BYPASS:     reg_view = {1'b1, 20'h00000, io_input_bypass};
				`OFS_OUT_BYPASS:    reg_view = {1'b1, 20'h00000, output_register_bypass};
				`OFS_STATE_CLK_SEL: reg_view = {1'b1, 16'h0000, state_clock_select};
				`OFS_DED_CLK_SEL:   reg_view = {1'b1, 20'h00000, dedicated_input_clock_select};
				`OFS_DED_BYPASS:    reg_view = {1'b1, 20'h00000, dedicated_input_bypass};
				`OFS_GLOBAL:        reg_view = {1'b1, 28'h0000000, global_reg};
				`OFS_PAIR_SEL:      reg_view = {1'b1, 26'h0000000, pair_input_select};
				`OFS_STORAGE_TYPE:  reg_view = {1'b1, 8'h00, storage_type};
				`OFS_SPLIT_LOW:     reg_view = {1'b1, 8'h00, 2'h0, split_reg[17:12],
					2'h0, split_reg[11:6], 2'h0, split_reg[5:0]};
				`OFS_SPLIT_HIGH:    reg_view = {1'b1, 8'h00, 2'h0, split_reg[35:30],
					2'h0, split_reg[29:24], 2'h0, split_reg[23:18]};
				`OFS_STATE_STATUS:  reg_view = {1'b1, 16'h0000, state_q};
				`OFS_FEED_STATUS:   reg_view = {1'b1, 2'h0, hidden_feed, pair_feed,
					macrocell_feed, 8'h00};
				default:            reg_view = {1'b0, 32'h00000000};
			endcase
		end
	endfunction

	always @* begin
		{rd_ok, rd_data} = reg_view(rd_addr);
		{wr_known, wr_old} = reg_view(wr_addr);
		wr_val = merge_bytes(wr_old, wr_data, wr_strb);
		// status is read only; configuration only while stopped, except the run bit
		wr_ok = (wr_addr == `OFS_GLOBAL) ||
			(!run && wr_known &&
			wr_addr != `OFS_STATE_STATUS && wr_addr != `OFS_FEED_STATUS);
	end

	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			oe_source_select             <= 12'h000;
			feedback_select              <= 12'h000;
			io_input_clock_select        <= 12'h000;
			io_input_bypass              <= 12'h000;
			output_register_bypass       <= 12'h000;
			state_clock_select           <= 16'h0000;
			dedicated_input_clock_select <= 12'h000;
			dedicated_input_bypass       <= 12'h000;
			global_reg                   <= 4'h0;
			pair_input_select            <= 6'h00;
			storage_type                 <= 24'h000000;
			split_reg                    <= {6{`SPLIT_RESET}};
		end else if (wr_strobe && wr_ok) begin
			case (wr_addr)
				`OFS_OE_SOURCE:     oe_source_select <= wr_val[11:0];
				`OFS_FEEDBACK:      feedback_select <= wr_val[11:0];
				`OFS_IO_CLK_SEL:    io_input_clock_select <= wr_val[11:0];
				`OFS_IO_BYPASS:     io_input_bypass <= wr_val[11:0];
				`OFS_OUT_BYPASS:    output_register_bypass <= wr_val[11:0];
				`OFS_STATE_CLK_SEL: state_clock_select <= wr_val[15:0];
				`OFS_DED_CLK_SEL:   dedicated_input_clock_select <= wr_val[11:0];
				`OFS_DED_BYPASS:    dedicated_input_bypass <= wr_val[11:0];
				`OFS_GLOBAL:        global_reg <= run ? {wr_val[3], global_reg[2:0]} :
					wr_val[3:0];
				`OFS_PAIR_SEL:      pair_input_select <= wr_val[5:0];
				`OFS_STORAGE_TYPE:  storage_type <= wr_val[23:0];
				`OFS_SPLIT_LOW:     split_reg[17:0] <= {wr_val[21:16], wr_val[13:8],
					wr_val[5:0]};
				`OFS_SPLIT_HIGH:    split_reg[35:18] <= {wr_val[21:16], wr_val[13:8],
					wr_val[5:0]};
				default:            global_reg <= global_reg;
			endcase
		end
	end

	// ==========================================================
	// clock selection and edge pulses
	wire input_clock_one_level = input_clock_one_pin_select ? pin_one_s : pin_two_s;
	wire input_clock_two_level = input_clock_two_pin_select ? pin_three_s : pin_two_s;
	wire sclk1_level = pin_one_s;
	wire state_clock_two_level = state_clock_two_pin_select ? pin_three_s : 1'b0;
	reg  [3:0] clk_prev;
	wire [3:0] clk_now = {state_clock_two_level, sclk1_level, input_clock_two_level, input_clock_one_level};
	wire [3:0] clk_rise = clk_now & ~clk_prev & {4{run}};
	wire input_clock_one = clk_rise[0];
	wire input_clock_two = clk_rise[1];
	wire state_clock_one = clk_rise[2];
	wire state_clock_two = clk_rise[3];

	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			clk_prev <= 4'h0;
		end else begin
			clk_prev <= clk_now;
		end
	end

	// ==========================================================
	// input registers and set/reset sampling
	reg  [11:0] io_inreg;
	reg  [11:0] ded_inreg;
	reg         set_sampled;
	reg         reset_sampled;
	wire [11:0] io_path = (io_input_bypass & io_s) | (~io_input_bypass & io_inreg);
	integer i;

	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			io_inreg      <= 12'h000;
			ded_inreg     <= 12'h000;
			set_sampled   <= 1'b0;
			reset_sampled <= 1'b0;
		end else begin
			for (i = 0; i < 12; i = i + 1) begin
				if (io_input_clock_select[i] ? input_clock_two : input_clock_one) begin
					io_inreg[i] <= io_s[i];
				end
				if (dedicated_input_clock_select[i] ? input_clock_two : input_clock_one) begin
					ded_inreg[i] <= ded_s[i];
				end
			end
			if (input_clock_one) begin
				set_sampled   <= set_term;
				reset_sampled <= reset_term;
			end
		end
	end

	// ==========================================================
	// array sums and state registers
	reg [11:0] io_sum;
	reg [15:0] state_next;
	integer c;
	integer s;

	always @* begin
		io_sum = 12'h000;
		for (c = 0; c < 12; c = c + 1) begin
			io_sum[c] = cell_sum(product_terms[(c/2)*32 +: 32], split_reg[(c/2)*6 +: 6],
				c[0]);
		end
		for (c = 0; c < 16; c = c + 1) begin
			if (c < 12) begin
				state_next[c] = next_state(storage_type[c*2 +: 2], state_q[c], io_sum[c],
					second_terms[c]);
			end else begin
				state_next[c] = hidden_terms[c-12];
			end
			if (reset_sampled) begin
				state_next[c] = 1'b0;
			end else if (set_sampled) begin
				state_next[c] = 1'b1;
			end
		end
	end

	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_q <= 16'h0000;
		end else begin
			for (s = 0; s < 16; s = s + 1) begin
				if (state_clock_select[s] ? state_clock_two : state_clock_one) begin
					state_q[s] <= state_next[s];
				end
			end
		end
	end

	// ==========================================================
	// pins and array feeds
	integer p;

	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			io_pin_out     <= 12'h000;
			io_pin_oe      <= 12'h000;
			dedicated_feed <= 12'h000;
			macrocell_feed <= 12'h000;
			pair_feed      <= 6'h00;
			hidden_feed    <= 4'h0;
		end else begin
			io_pin_out     <= (output_register_bypass & io_sum) |
				(~output_register_bypass & state_q[11:0]);
			io_pin_oe      <= {12{run}} & ((oe_source_select & {12{oe_pin_s}}) |
				(~oe_source_select & oe_terms));
			dedicated_feed <= (dedicated_input_bypass & ded_s) |
				(~dedicated_input_bypass & ded_inreg);
			macrocell_feed <= (feedback_select & io_path) |
				(~feedback_select & state_q[11:0]);
			hidden_feed    <= state_q[15:12];
			for (p = 0; p < 6; p = p + 1) begin
				pair_feed[p] <= pair_input_select[p] ? io_path[p*2+1] : io_path[p*2];
			end
		end
	end
endmodule // state_macrocell_fabric

// ### tb/fabric_checker.sv
// register bus assertions for the macrocell fabric
`timescale 1ns/100ps
`include "fabric_consts.vh"
module fabric_checker (
	input wire        clock,
	input wire        rst_b,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	// ==========================================================
	// handshake relations
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response withdrawn early");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data withdrawn early");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during pending response");
	a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_wready)
		else $error("data taken during pending response");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during pending read data");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_error_data: assert property (
		s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
		else $error("refused read returns data");
	c_write_refused: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
	c_read_refused: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule // fabric_checker

bind state_macrocell_fabric fabric_checker chk (
	.clock, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// ### tb/pin_partner.sv
// far-side model: clock pins and io pin resolution
`timescale 1ns/100ps
module pin_partner (
	input  wire        clock,
	input  wire [11:0] io_pin_out,
	input  wire [11:0] io_pin_oe,
	input  wire [11:0] ext_drive,
	output reg         clk_pin_one,
	output reg         clk_pin_two,
	output reg         clk_pin_three,
	output wire [11:0] io_pin_in
);
	// the fabric wins a pin while it drives it
	assign io_pin_in = (io_pin_oe & io_pin_out) | (~io_pin_oe & ext_drive);
	initial begin
		clk_pin_one = 1'b0;
		clk_pin_two = 1'b0;
		clk_pin_three = 1'b0;
	end
	// clock pins idle low; one pulse is three cycles high, three low
	task pulse_pin(input [1:0] which);
		begin
			@(posedge clock);
			clk_pin_one <= (which == 2'h1);
			clk_pin_two <= (which == 2'h2);
			clk_pin_three <= (which == 2'h3);
			repeat (3) @(posedge clock);
			clk_pin_one <= 1'b0;
			clk_pin_two <= 1'b0;
			clk_pin_three <= 1'b0;
			repeat (3) @(posedge clock);
		end
	endtask
endmodule // pin_partner

// ### tb/configurable_state_macrocells_tb_top.sv
// testbench for the macrocell fabric
`timescale 1ns/100ps
`include "fabric_consts.vh"
module configurable_state_macrocells_tb_top;
	reg          clock, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg          s_axi_arvalid, s_axi_rready, common_oe_pin, set_term, reset_term;
	reg  [7:0]   s_axi_awaddr, s_axi_araddr;
	reg  [31:0]  s_axi_wdata;
	reg  [3:0]   s_axi_wstrb, hidden_terms;
	reg  [11:0]  dedicated_pin, second_terms, oe_terms, ext_drive;
	reg  [191:0] product_terms;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         clk_pin_one, clk_pin_two, clk_pin_three;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [11:0]  io_pin_in, io_pin_out, io_pin_oe, dedicated_feed, macrocell_feed;
	wire [5:0]   pair_feed;
	wire [3:0]   hidden_feed;
	integer      mismatches, checks_done, i;

	state_macrocell_fabric uut (
		.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clk_pin_one, .clk_pin_two,
		.clk_pin_three, .common_oe_pin, .io_pin_in, .io_pin_out, .io_pin_oe,
		.dedicated_pin, .product_terms, .second_terms, .oe_terms, .hidden_terms,
		.set_term, .reset_term, .dedicated_feed, .macrocell_feed, .pair_feed, .hidden_feed
	);
	pin_partner partner (
		.clock, .io_pin_out, .io_pin_oe, .ext_drive, .clk_pin_one, .clk_pin_two,
		.clk_pin_three, .io_pin_in
	);

	// ==========================================================
	// verdict, comparison and bus tasks
	task print_verdict;
		begin
			if (mismatches == 0 && checks_done > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task compare(input [31:0] got, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task axi_write(input [7:0] a, input [31:0] d, input [1:0] er);
		integer n;
		reg aw, w, b;
		begin
			b = 1'b0;
			@(posedge clock);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			for (n = 0; n < 50 && !b; n = n + 1) begin
				@(negedge clock);
				aw = s_axi_awvalid && s_axi_awready;
				w = s_axi_wvalid && s_axi_wready;
				b = s_axi_bvalid;
				if (b) compare({30'h0, s_axi_bresp}, {30'h0, er});
				@(posedge clock);
				if (aw) s_axi_awvalid <= 1'b0;
				if (w) s_axi_wvalid <= 1'b0;
				if (b) s_axi_bready <= 1'b0;
			end
			if (!b) begin
				mismatches = mismatches + 1;
				print_verdict;
			end
		end
	endtask
	task axi_read(input [7:0] a, input [31:0] ed, input [1:0] er);
		integer n;
		reg ar, r;
		begin
			r = 1'b0;
			@(posedge clock);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			for (n = 0; n < 50 && !r; n = n + 1) begin
				@(negedge clock);
				ar = s_axi_arvalid && s_axi_arready;
				r = s_axi_rvalid;
				if (r) compare(s_axi_rdata, ed);
				if (r) compare({30'h0, s_axi_rresp}, {30'h0, er});
				@(posedge clock);
				if (ar) s_axi_arvalid <= 1'b0;
				if (r) s_axi_rready <= 1'b0;
			end
			if (!r) begin
				mismatches = mismatches + 1;
				print_verdict;
			end
		end
	endtask

	// ==========================================================
	// scenarios
	task check_defaults;
		begin
			for (i = 0; i < 11; i = i + 1)
				axi_read(8'h04 * i[5:0], 32'h0, `RESP_OKAY);
			axi_read(`OFS_SPLIT_LOW, 32'h00101010, `RESP_OKAY);
			axi_read(`OFS_SPLIT_HIGH, 32'h00101010, `RESP_OKAY);
			axi_read(8'h3C, 32'h0, `RESP_SLVERR);
		end
	endtask
	task check_readback;
		begin
			axi_write(`OFS_STATE_CLK_SEL, 32'hFFFFFFFF, `RESP_OKAY);
			axi_read(`OFS_STATE_CLK_SEL, 32'h0000FFFF, `RESP_OKAY);
			axi_write(`OFS_PAIR_SEL, 32'hFFFFFFFF, `RESP_OKAY);
			axi_read(`OFS_PAIR_SEL, 32'h0000003F, `RESP_OKAY);
			s_axi_wstrb <= 4'h1;
			axi_write(`OFS_FEEDBACK, 32'h00000FFF, `RESP_OKAY);
			axi_read(`OFS_FEEDBACK, 32'h000000FF, `RESP_OKAY);
			s_axi_wstrb <= 4'hF;
			axi_write(`OFS_FEED_STATUS, 32'h00000001, `RESP_SLVERR);
		end
	endtask
	task check_fabric;
		begin
			axi_write(`OFS_DED_BYPASS, 32'hF00, `RESP_OKAY);
			axi_write(`OFS_DED_CLK_SEL, 32'hF0, `RESP_OKAY);
			axi_write(`OFS_OE_SOURCE, 32'hF0, `RESP_OKAY);
			axi_write(`OFS_OUT_BYPASS, 32'h1, `RESP_OKAY);
			axi_write(`OFS_GLOBAL, 32'h9, `RESP_OKAY);
			dedicated_pin <= 12'h5A3;
			oe_terms <= 12'hA5A;
			ext_drive <= 12'hFFF;
			common_oe_pin <= 1'b1;
			product_terms <= 192'h1;
			repeat (8) @(posedge clock);
			@(negedge clock);
			compare({20'h0, dedicated_feed}, 32'h500);
			compare({20'h0, io_pin_oe}, 32'hAFA);
			compare({20'h0, io_pin_out}, 32'h1);
			partner.pulse_pin(2'h2);
			repeat (4) @(posedge clock);
			@(negedge clock);
			compare({20'h0, dedicated_feed}, 32'h503);
			compare({10'h0, pair_feed, hidden_feed, macrocell_feed}, 32'h5);
			partner.pulse_pin(2'h3);
			repeat (4) @(posedge clock);
			@(negedge clock);
			compare({20'h0, dedicated_feed}, 32'h5A3);
		end
	endtask
	task check_locked;
		begin
			axi_write(`OFS_OE_SOURCE, 32'h00000000, `RESP_SLVERR);
			axi_read(`OFS_OE_SOURCE, 32'h000000F0, `RESP_OKAY);
			axi_write(`OFS_GLOBAL, 32'h00000000, `RESP_OKAY);
			axi_read(`OFS_GLOBAL, 32'h00000001, `RESP_OKAY);
			axi_write(`OFS_OE_SOURCE, 32'h00000000, `RESP_OKAY);
			repeat (4) @(posedge clock);
			@(negedge clock);
			compare({20'h0, io_pin_oe}, 32'h00000000);
		end
	endtask

	// ==========================================================
	// clock, reset, sequence and watchdog
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		mismatches = mismatches + 1;
		print_verdict;
	end
	initial begin
		mismatches = 0;
		checks_done = 0;
		rst_b = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{common_oe_pin, set_term, reset_term} = 3'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		hidden_terms = 4'h0;
		{dedicated_pin, second_terms, oe_terms, ext_drive} = 48'h000000000000;
		product_terms = 192'h0;
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock);
		check_defaults;
		check_readback;
		check_fabric;
		check_locked;
		print_verdict;
	end
endmodule // configurable_state_macrocells_tb_top
